/* design/ccbu_top.sv */
// conditional branch unit on second-coprocessor condition bits
`timescale 1ns/1ps
`default_nettype none
`include "ccbu_defines.svh"

// Function
// - An issued word with major opcode 010010 and format 01000 is a family branch.
// - Target is the delay-slot address plus the displacement shifted by two, sign-extended.
// - With the select bit clear the branch is taken when the chosen condition bit is 0.
// - With the select bit set the branch is taken when the chosen condition bit is 1.
// - A taken branch redirects the program counter only after the delay slot executed.
// - The condition is sampled at the branch and applied at the following position.
// - Likely forms cancel the delay-slot instruction when the branch is not taken.
// - The short assembler form is condition index zero.
// - The branch can raise coprocessor-unusable or reserved-instruction exceptions.
module ccbu_top
   import ccbu_pkg::*;
#(
   parameter int unsigned COND_BITS = 8
)
(
   input  wire logic                 clock,        // core clock, 100 MHz
   input  wire logic                 rst,          // synchronous reset
   input  wire logic                 ce,           // clock enable
   input  wire logic                 issueValid,   // instruction at issue position
   input  wire logic [31:0]          issueInstr,   // instruction word
   input  wire logic [31:0]          issuePc,      // address of that instruction
   input  wire logic [COND_BITS-1:0] cop2Cond,     // coprocessor condition bits
   output logic                      nullifySlot,  // cancel the delay slot
   output ccbu_redirect_type         redirect,     // program counter load
   output logic                      excValid,     // exception pulse
   output ccbu_exc_type              excCode,      // exception kind
   output logic                      slotPending,  // waiting for delay slot
   input  wire logic [7:0]           regAddr,      // register address
   input  wire logic [31:0]          regWdata,     // register write data
   input  wire logic                 regWr,        // write strobe
   input  wire logic                 regRd,        // read strobe
   output logic [31:0]               regRdata,     // read data, next cycle
   output logic                      irq           // level interrupt
);

   //--------------------------------------------------------------------
   // declarations
   //--------------------------------------------------------------------
   ccbu_state_type          state_ff;
   ccbu_state_type          nxt_state;
   ccbu_fields_type         fld;
   logic                    isFamily;
   logic [31:0]             dispOffset;
   logic                    selBit;
   logic                    takenNow;
   logic                    brSeen;
   logic                    cpuFault;
   logic                    riFault;
   logic                    brAccept;
   logic                    slotDone;
   logic                    pendTaken_ff;
   logic [31:0]             pendTarget_ff;
   logic                    nullifySlot_ff;
   ccbu_redirect_type       redirect_ff;
   logic                    excValid_ff;
   ccbu_exc_type            excCode_ff;
   logic [`CCBU_CTRL_W-1:0] ctrl_ff;
   logic [31:0]             takenCount_ff;
   logic [31:0]             nulledCount_ff;
   logic [31:0]             lastTarget_ff;
   logic [31:0]             rdata_ff;
   logic [31:0]             rdMux;
   logic [`CCBU_EV_W-1:0]   events;
   logic [`CCBU_EV_W-1:0]   intStatus;
   logic [`CCBU_EV_W-1:0]   intEnable;

   //--------------------------------------------------------------------
   // decode and condition test
   //--------------------------------------------------------------------
   ccbu_decode u_decode (
      .instr      (issueInstr),
      .isFamily   (isFamily),
      .fields     (fld),
      .dispOffset (dispOffset)
   );

   // vector is stable from the coprocessor, same clock
   assign selBit = cop2Cond[fld.conditionIndex];

   always_comb
   begin
      if (fld.trueFalseSelect)
         takenNow = selBit;
      else
         takenNow = ~selBit;
   end

   // only decode outside the slot; a branch in the slot is not looked at
   assign brSeen   = ce & issueValid & (state_ff == CCBU_IDLE) & isFamily;
   assign cpuFault = brSeen & ~ctrl_ff[`CCBU_CTRL_USABLE];
   assign riFault  = brSeen & ~cpuFault & fld.nullifyDelayBit
                   & ~ctrl_ff[`CCBU_CTRL_LIKELY];
   assign brAccept = brSeen & ~cpuFault & ~riFault;
   assign slotDone = ce & issueValid & (state_ff == CCBU_SLOT);

   //--------------------------------------------------------------------
   // sequencer
   //--------------------------------------------------------------------
   always_comb
   begin
      nxt_state = state_ff;
      case (state_ff)
         CCBU_IDLE: if (brAccept) nxt_state = CCBU_SLOT;
         CCBU_SLOT: if (slotDone) nxt_state = CCBU_IDLE;
         default:   nxt_state = CCBU_IDLE;
      endcase
   end

   always_ff @(posedge clock)
   begin
      if (rst)
         state_ff <= CCBU_IDLE;
      else if (ce)
         state_ff <= nxt_state;
   end

   //--------------------------------------------------------------------
   // pending branch: sampled at the branch, used at the slot
   //--------------------------------------------------------------------
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         pendTaken_ff   <= 1'b0;
         pendTarget_ff  <= `CCBU_ZERO32;
         nullifySlot_ff <= 1'b0;
      end
      else if (ce)
      begin
         if (brAccept)
         begin
            pendTaken_ff   <= takenNow;
            pendTarget_ff  <= issuePc + `CCBU_SLOT_STEP + dispOffset;
            // zero for normal forms, slot always runs
            nullifySlot_ff <= fld.nullifyDelayBit & ~takenNow;
         end
         else if (slotDone)
            nullifySlot_ff <= 1'b0;
      end
   end

   //--------------------------------------------------------------------
   // redirect after the slot instruction
   //--------------------------------------------------------------------
   always_ff @(posedge clock)
   begin
      if (rst)
         redirect_ff <= '0;
      else if (ce)
      begin
         redirect_ff.load <= slotDone & pendTaken_ff;
         if (slotDone && pendTaken_ff)
            redirect_ff.target <= pendTarget_ff;
      end
   end

   //--------------------------------------------------------------------
   // exceptions
   //--------------------------------------------------------------------
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         excValid_ff <= 1'b0;
         excCode_ff  <= EXC_NONE;
      end
      else if (ce)
      begin
         excValid_ff <= cpuFault | riFault;
         if (cpuFault)
            excCode_ff <= EXC_COP_UNUSABLE;
         else if (riFault)
            excCode_ff <= EXC_RESERVED;
         else
            excCode_ff <= EXC_NONE;
      end
   end

   //--------------------------------------------------------------------
   // statistics
   //--------------------------------------------------------------------
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         takenCount_ff  <= `CCBU_ZERO32;
         nulledCount_ff <= `CCBU_ZERO32;
         lastTarget_ff  <= `CCBU_ZERO32;
      end
      else if (ce && slotDone)
      begin
         if (pendTaken_ff)
         begin
            takenCount_ff <= takenCount_ff + `CCBU_SLOT_STEP / `CCBU_SLOT_STEP;
            lastTarget_ff <= pendTarget_ff;
         end
         if (nullifySlot_ff)
            nulledCount_ff <= nulledCount_ff + `CCBU_SLOT_STEP / `CCBU_SLOT_STEP;
      end
   end

   //--------------------------------------------------------------------
   // interrupts
   //--------------------------------------------------------------------
   always_comb
   begin
      events                    = `CCBU_EV_RST;
      events[`CCBU_EV_TAKEN]    = slotDone & pendTaken_ff;
      events[`CCBU_EV_NULLED]   = slotDone & nullifySlot_ff;
      events[`CCBU_EV_UNUSABLE] = cpuFault;
      events[`CCBU_EV_RESERVED] = riFault;
   end

   ccbu_irq #(
      .EV_W (`CCBU_EV_W)
   ) u_irq (
      .clock    (clock),
      .rst      (rst),
      .ce       (ce),
      .events   (events),
      .wrEnable (regWr && regAddr == `CCBU_REG_INTEN),
      .wrClear  (regWr && regAddr == `CCBU_REG_INTCLR),
      .wrData   (regWdata[`CCBU_EV_W-1:0]),
      .status   (intStatus),
      .enable   (intEnable),
      .irq      (irq)
   );

   //--------------------------------------------------------------------
   // register port
   //--------------------------------------------------------------------
   always_ff @(posedge clock)
   begin
      if (rst)
         ctrl_ff <= `CCBU_CTRL_RST;
      else if (ce && regWr && regAddr == `CCBU_REG_CTRL)
         ctrl_ff <= regWdata[`CCBU_CTRL_W-1:0];
   end

   always_comb
   begin
      rdMux = `CCBU_ZERO32;
      case (regAddr)
         `CCBU_REG_CTRL:    rdMux[`CCBU_CTRL_W-1:0] = ctrl_ff;
         `CCBU_REG_STATUS:  rdMux[`CCBU_STAT_W-1:0] =
                               {pendTaken_ff, nullifySlot_ff, state_ff};
         `CCBU_REG_INTSTAT: rdMux[`CCBU_EV_W-1:0] = intStatus;
         `CCBU_REG_INTEN:   rdMux[`CCBU_EV_W-1:0] = intEnable;
         `CCBU_REG_TAKEN:   rdMux = takenCount_ff;
         `CCBU_REG_NULLED:  rdMux = nulledCount_ff;
         `CCBU_REG_TARGET:  rdMux = lastTarget_ff;
         default:           rdMux = `CCBU_ZERO32;
      endcase
   end

   // data stands only in the cycle after the read strobe
   always_ff @(posedge clock)
   begin
      if (rst)
         rdata_ff <= `CCBU_ZERO32;
      else if (ce)
         rdata_ff <= regRd ? rdMux : `CCBU_ZERO32;
   end

   assign nullifySlot = nullifySlot_ff;
   assign redirect    = redirect_ff;
   assign excValid    = excValid_ff;
   assign excCode     = excCode_ff;
   assign slotPending = (state_ff == CCBU_SLOT);
   assign regRdata    = rdata_ff;

   //--------------------------------------------------------------------
   // checks
   //--------------------------------------------------------------------
   logic [31:0] chkTarget;
   logic        chkSel;
   logic        chkTf;
   logic        chkNd;
   logic        chkTaken;

   assign chkSel    = cop2Cond[issueInstr[`CCBU_CC_HI:`CCBU_CC_LO]];
   assign chkTf     = issueInstr[`CCBU_TF_BIT];
   assign chkNd     = issueInstr[`CCBU_ND_BIT];
   assign chkTaken  = chkTf ? chkSel : ~chkSel;
   assign chkTarget = issuePc + `CCBU_SLOT_STEP
                    + {{`CCBU_EXT_BITS{issueInstr[`CCBU_DISP_HI]}},
                       issueInstr[`CCBU_DISP_HI:`CCBU_DISP_LO],
                       {`CCBU_DISP_SHIFT{1'b0}}};

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (rst);

   sequence s_family_issue;
      ce && issueValid && state_ff == CCBU_IDLE
      && issueInstr[`CCBU_OPC_HI:`CCBU_OPC_LO] == `CCBU_OPC_SECOND_COPROCESSOR_OPCODE
      && issueInstr[`CCBU_FMT_HI:`CCBU_FMT_LO] == `CCBU_FMT_BC;
   endsequence

   sequence s_slot_wait;
      state_ff == CCBU_SLOT && !slotDone;
   endsequence

   a_family_accept: assert property (
      s_family_issue ##0 (ctrl_ff[`CCBU_CTRL_USABLE]
         && !(chkNd && !ctrl_ff[`CCBU_CTRL_LIKELY]))
      |=> state_ff == CCBU_SLOT)
      else $error("family branch not accepted");
   a_target_calc: assert property (
      brAccept |=> pendTarget_ff == $past(chkTarget))
      else $error("branch target wrong");
   a_false_take: assert property (
      brAccept && !chkTf |=> pendTaken_ff == !$past(chkSel))
      else $error("false branch decision wrong");
   a_true_take: assert property (
      brAccept && chkTf |=> pendTaken_ff == $past(chkSel))
      else $error("true branch decision wrong");
   a_redirect_slot: assert property (
      slotDone && pendTaken_ff
      |=> redirect_ff.load && redirect_ff.target == $past(pendTarget_ff))
      else $error("redirect missing after slot");
   a_no_early: assert property (
      brAccept |=> !redirect_ff.load ##0 state_ff == CCBU_SLOT)
      else $error("redirect before slot");
   a_hold_sample: assert property (
      s_slot_wait |=> $stable(pendTaken_ff) && $stable(pendTarget_ff))
      else $error("sampled condition changed");
   a_likely_cancel: assert property (
      brAccept && chkNd && !chkTaken |=> nullifySlot_ff)
      else $error("likely slot not cancelled");
   a_cancel_end: assert property (
      slotDone |=> !nullifySlot_ff && state_ff == CCBU_IDLE)
      else $error("cancel outlived slot");
   a_short_form: assert property (
      brAccept && issueInstr[`CCBU_CC_HI:`CCBU_CC_LO] == `CCBU_CC_ZERO
      |=> pendTaken_ff == ($past(chkTf) ~^ $past(cop2Cond[`CCBU_CC_ZERO])))
      else $error("index zero decision wrong");
   a_unusable_exc: assert property (
      s_family_issue ##0 !ctrl_ff[`CCBU_CTRL_USABLE]
      |=> excValid_ff && excCode_ff == EXC_COP_UNUSABLE
          && state_ff == CCBU_IDLE)
      else $error("unusable exception missing");
   a_reserved_exc: assert property (
      s_family_issue ##0 (ctrl_ff[`CCBU_CTRL_USABLE] && chkNd
         && !ctrl_ff[`CCBU_CTRL_LIKELY])
      |=> excValid_ff && excCode_ff == EXC_RESERVED)
      else $error("reserved exception missing");
   a_normal_slot: assert property (
      brAccept && !chkNd |=> !nullifySlot_ff)
      else $error("normal slot cancelled");

endmodule // ccbu_top

`default_nettype wire

/* design/ccbu_defines.svh */
// encodings, field positions, register offsets and reset values
`ifndef CCBU_DEFINES_SVH
`define CCBU_DEFINES_SVH

// instruction encoding
`define CCBU_OPC_SECOND_COPROCESSOR_OPCODE    6'h12
`define CCBU_FMT_BC      5'h08
`define CCBU_OPC_HI      31
`define CCBU_OPC_LO      26
`define CCBU_FMT_HI      25
`define CCBU_FMT_LO      21
`define CCBU_CC_HI       20
`define CCBU_CC_LO       18
`define CCBU_ND_BIT      17
`define CCBU_TF_BIT      16
`define CCBU_DISP_HI     15
`define CCBU_DISP_LO     0
`define CCBU_DISP_SHIFT  2
`define CCBU_EXT_BITS    14
`define CCBU_SLOT_STEP   32'h00000004
`define CCBU_ZERO32      32'h00000000
`define CCBU_CC_ZERO     3'h0

// register offsets
`define CCBU_REG_CTRL    8'h00
`define CCBU_REG_STATUS  8'h04
`define CCBU_REG_INTSTAT 8'h08
`define CCBU_REG_INTEN   8'h0C
`define CCBU_REG_INTCLR  8'h10
`define CCBU_REG_TAKEN   8'h14
`define CCBU_REG_NULLED  8'h18
`define CCBU_REG_TARGET  8'h1C

// control fields
`define CCBU_CTRL_W      2
`define CCBU_CTRL_USABLE 0
`define CCBU_CTRL_LIKELY 1
`define CCBU_CTRL_RST    2'h3
`define CCBU_STAT_W      4

// interrupt event bits
`define CCBU_EV_W        4
`define CCBU_EV_TAKEN    0
`define CCBU_EV_NULLED   1
`define CCBU_EV_UNUSABLE 2
`define CCBU_EV_RESERVED 3
`define CCBU_EV_RST      4'h0

`endif

/* design/ccbu_pkg.sv */
// types shared by the branch unit files
`default_nettype none

package ccbu_pkg;

   typedef enum logic [1:0] {
      CCBU_IDLE = 2'b00,
      CCBU_SLOT = 2'b01
   } ccbu_state_type;

   typedef enum logic [1:0] {
      EXC_NONE         = 2'b00,
      EXC_COP_UNUSABLE = 2'b01,
      EXC_RESERVED     = 2'b10
   } ccbu_exc_type;

   typedef struct packed {
      logic [2:0]  conditionIndex;
      logic        nullifyDelayBit;
      logic        trueFalseSelect;
      logic [15:0] disp;
   } ccbu_fields_type;

   typedef struct packed {
      logic        load;
      logic [31:0] target;
   } ccbu_redirect_type;

endpackage

`default_nettype wire

/* design/ccbu_decode.sv */
// field decoder and displacement extender for the branch family
`timescale 1ns/1ps
`default_nettype none
`include "ccbu_defines.svh"

module ccbu_decode
   import ccbu_pkg::*;
(
   input  wire logic [31:0]     instr,      // instruction word
   output logic                 isFamily,   // word is one of the four branches
   output ccbu_fields_type      fields,     // extracted fields
   output logic [31:0]          dispOffset  // sign-extended byte offset
);

   assign isFamily = (instr[`CCBU_OPC_HI:`CCBU_OPC_LO] == `CCBU_OPC_SECOND_COPROCESSOR_OPCODE)
                   && (instr[`CCBU_FMT_HI:`CCBU_FMT_LO] == `CCBU_FMT_BC);

   // short form assembles to index zero, so no special case here
   assign fields.conditionIndex  = instr[`CCBU_CC_HI:`CCBU_CC_LO];
   assign fields.nullifyDelayBit = instr[`CCBU_ND_BIT];
   assign fields.trueFalseSelect = instr[`CCBU_TF_BIT];
   assign fields.disp            = instr[`CCBU_DISP_HI:`CCBU_DISP_LO];

   assign dispOffset = {{`CCBU_EXT_BITS{fields.disp[`CCBU_DISP_HI]}},
                        fields.disp, {`CCBU_DISP_SHIFT{1'b0}}};

endmodule // ccbu_decode

`default_nettype wire

/* design/ccbu_irq.sv */
// sticky event status, enable mask and level interrupt
`timescale 1ns/1ps
`default_nettype none
`include "ccbu_defines.svh"

module ccbu_irq
#(
   parameter int unsigned EV_W = `CCBU_EV_W
)
(
   input  wire logic            clock,     // core clock
   input  wire logic            rst,       // synchronous reset
   input  wire logic            ce,        // clock enable
   input  wire logic [EV_W-1:0] events,    // one-cycle event pulses
   input  wire logic            wrEnable,  // write of enable register
   input  wire logic            wrClear,   // write of clear register
   input  wire logic [EV_W-1:0] wrData,    // write data
   output logic [EV_W-1:0]      status,    // sticky status
   output logic [EV_W-1:0]      enable,    // enable mask
   output logic                 irq        // level interrupt
);

   logic [EV_W-1:0] status_ff;
   logic [EV_W-1:0] enable_ff;

   // a new event beats a clear in the same cycle
   genvar g;
   generate
      for (g = 0; g < EV_W; g++)
      begin : g_stat
         always_ff @(posedge clock)
         begin
            if (rst)
               status_ff[g] <= 1'b0;
            else if (ce && events[g])
               status_ff[g] <= 1'b1;
            else if (ce && wrClear && wrData[g])
               status_ff[g] <= 1'b0;
         end
      end
   endgenerate

   always_ff @(posedge clock)
   begin
      if (rst)
         enable_ff <= EV_W'(`CCBU_EV_RST);
      else if (ce && wrEnable)
         enable_ff <= wrData;
   end

   assign status = status_ff;
   assign enable = enable_ff;
   assign irq    = |(status_ff & enable_ff);

endmodule // ccbu_irq

`default_nettype wire

/* testbench/ccbu_second_coprocessor_opcode_model.sv */
// coprocessor model presenting the condition bit vector
`timescale 1ns/1ps
`default_nettype none

module ccbu_second_coprocessor_opcode_model
#(
   parameter int unsigned N = 8
)
(
   input  wire logic         clock,  // core clock
   input  wire logic         rst,    // synchronous reset
   input  wire logic         load,   // take a new vector
   input  wire logic [N-1:0] value,  // new vector
   output logic [N-1:0]      cond    // condition bits
);
   // vector only moves on request, stable otherwise
   always_ff @(posedge clock)
   begin
      if (rst)
         cond <= '0;
      else if (load)
         cond <= value;
   end
endmodule // ccbu_second_coprocessor_opcode_model

`default_nettype wire

/* testbench/ccbu_top_bench.sv */
// self-checking bench for the coprocessor branch unit
`timescale 1ns/1ps
`default_nettype none

module ccbu_top_bench;
   import ccbu_pkg::*;
   logic              clock;
   logic              rst;
   logic              ce;
   logic              issueValid;
   logic [31:0]       issueInstr;
   logic [31:0]       issuePc;
   logic              condLoad;
   logic [7:0]        condValue;
   logic [7:0]        cop2Cond;
   logic              nullifySlot;
   ccbu_redirect_type redirect;
   logic              excValid;
   ccbu_exc_type      excCode;
   logic              slotPending;
   logic [7:0]        regAddr;
   logic [31:0]       regWdata;
   logic              regWr;
   logic              regRd;
   logic [31:0]       regRdata;
   logic              irq;
   int                errors;
   int                checksDone;

   ccbu_top u_ccbu_top (.clock(clock), .rst(rst), .ce(ce), .issueValid(issueValid),
      .issueInstr(issueInstr), .issuePc(issuePc), .cop2Cond(cop2Cond),
      .nullifySlot(nullifySlot), .redirect(redirect), .excValid(excValid),
      .excCode(excCode), .slotPending(slotPending), .regAddr(regAddr),
      .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
      .irq(irq));

   ccbu_second_coprocessor_opcode_model u_ccbu_second_coprocessor_opcode_model (.clock(clock), .rst(rst), .load(condLoad),
      .value(condValue), .cond(cop2Cond));

   initial
   begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checksDone++;
      if (got !== exp)
      begin
         errors++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic summarize;
      $display("errors %0d checks %0d", errors, checksDone);
      if (errors == 0 && checksDone > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clock);
      regWr <= 1'b1;
      regAddr <= a;
      regWdata <= d;
      @(posedge clock);
      regWr <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      @(posedge clock);
      regRd <= 1'b1;
      regAddr <= a;
      @(posedge clock);
      regRd <= 1'b0;
      #1 chk("regRdata", exp, regRdata);
   endtask

   task automatic setCond(input logic [7:0] v);
      @(posedge clock);
      condLoad <= 1'b1;
      condValue <= v;
      @(posedge clock);
      condLoad <= 1'b0;
   endtask

   // branch, then a plain slot word, then the redirect cycle
   task automatic br(input logic [31:0] w, pc, input logic nul, ld, input logic [31:0] tgt);
      @(posedge clock);
      issueValid <= 1'b1;
      issueInstr <= w;
      issuePc <= pc;
      @(posedge clock);
      issueInstr <= 32'h00000000;
      issuePc <= pc + 32'h00000004;
      #1 chk("slotPending", 32'h1, {31'h0, slotPending});
      chk("nullifySlot", {31'h0, nul}, {31'h0, nullifySlot});
      chk("load early", 32'h0, {31'h0, redirect.load});
      @(posedge clock);
      issueValid <= 1'b0;
      #1 chk("redirect.load", {31'h0, ld}, {31'h0, redirect.load});
      if (ld)
         chk("redirect.target", tgt, redirect.target);
      chk("nullify end", 32'h0, {31'h0, nullifySlot});
   endtask

   task automatic oneWord(input logic [31:0] w, input logic ex, input logic [1:0] code);
      @(posedge clock);
      issueValid <= 1'b1;
      issueInstr <= w;
      @(posedge clock);
      issueValid <= 1'b0;
      #1 chk("excValid", {31'h0, ex}, {31'h0, excValid});
      chk("excCode", {30'h0, code}, {30'h0, excCode});
      chk("no slot", 32'h0, {31'h0, slotPending});
   endtask

   task automatic testRegs;
      rd(8'h00, 32'h00000003);
      rd(8'h0C, 32'h00000000);
      rd(8'h40, 32'h00000000);
      $display("test regs done");
   endtask

   // all four forms, both outcomes, several indices and signs
   task automatic testForms;
      logic [2:0]  cc;
      logic [15:0] d;
      logic        t;
      logic [31:0] pc;
      for (int k = 0; k < 4; k++)
         for (int v = 0; v < 2; v++)
         begin
            cc = 3'(k * 2 + v);
            d = v ? 16'hFFFC : 16'h0010;
            pc = 32'h00001000 + 32'(k * 64);
            t = (v[0] == k[0]);
            setCond(v ? (8'h01 << cc) : ~(8'h01 << cc));
            br({6'h12, 5'h08, cc, k[1], k[0], d}, pc, k[1] & !t, t,
               pc + 32'h4 + {{14{d[15]}}, d, 2'b00});
         end
      oneWord({6'h11, 5'h08, 21'h0}, 1'b0, 2'b00);
      rd(8'h14, 32'h00000004);
      rd(8'h18, 32'h00000002);
      rd(8'h1C, 32'h000010B4);
      $display("test forms done");
   endtask

   task automatic testExc;
      wr(8'h00, 32'h00000002);
      oneWord({6'h12, 5'h08, 3'h0, 2'b01, 16'h0004}, 1'b1, 2'b01);
      wr(8'h00, 32'h00000001);
      oneWord({6'h12, 5'h08, 3'h0, 2'b11, 16'h0004}, 1'b1, 2'b10);
      wr(8'h00, 32'h00000003);
      $display("test exceptions done");
   endtask

   // condition flips while the slot waits; the decision must not follow it
   task automatic testSample;
      setCond(8'h00);
      @(posedge clock);
      issueValid <= 1'b1;
      issueInstr <= {6'h12, 5'h08, 3'h0, 2'b01, 16'h0004};
      issuePc <= 32'h00003000;
      condLoad <= 1'b1;
      condValue <= 8'hFF;
      @(posedge clock);
      issueInstr <= 32'h00000000;
      condLoad <= 1'b0;
      @(posedge clock);
      issueValid <= 1'b0;
      #1 chk("sampled cond", 32'h0, {31'h0, redirect.load});
      $display("test sample done");
   endtask

   // a frozen block ignores an issued branch
   task automatic testHold;
      @(posedge clock);
      ce <= 1'b0;
      issueValid <= 1'b1;
      issueInstr <= {6'h12, 5'h08, 3'h0, 2'b00, 16'h0004};
      @(posedge clock);
      ce <= 1'b1;
      issueValid <= 1'b0;
      #1 chk("frozen issue", 32'h0, {31'h0, slotPending});
      $display("test hold done");
   endtask

   task automatic testIrq;
      wr(8'h10, 32'h0000000F);
      rd(8'h08, 32'h00000000);
      wr(8'h0C, 32'h00000002);
      setCond(8'hFF);
      br({6'h12, 5'h08, 3'h2, 2'b10, 16'h0008}, 32'h00002000, 1'b1, 1'b0, 32'h0);
      #1 chk("irq set", 32'h1, {31'h0, irq});
      rd(8'h08, 32'h00000002);
      wr(8'h0C, 32'h00000000);
      #1 chk("irq masked", 32'h0, {31'h0, irq});
      wr(8'h0C, 32'h00000002);
      wr(8'h10, 32'h00000002);
      #1 chk("irq cleared", 32'h0, {31'h0, irq});
      rd(8'h10, 32'h00000000);
      $display("test interrupt done");
   endtask

   initial
   begin
      repeat (3000) @(posedge clock);
      errors++;
      summarize();
   end

   initial
   begin
      errors = 0;
      checksDone = 0;
      rst = 1'b1;
      ce = 1'b1;
      issueValid = 1'b0;
      issueInstr = 32'h00000000;
      issuePc = 32'h00000000;
      condLoad = 1'b0;
      condValue = 8'h00;
      regAddr = 8'h00;
      regWdata = 32'h00000000;
      regWr = 1'b0;
      regRd = 1'b0;
      repeat (3) @(posedge clock);
      rst <= 1'b0;
      testRegs();
      testForms();
      testExc();
      testSample();
      testHold();
      testIrq();
      summarize();
   end
endmodule // ccbu_top_bench

`default_nettype wire
